/* File: src/sensor_i2c_target_bus_layer.sv */
// bus layer of a two-wire sensor target: bit timing, start/stop, address, ack
// assumes external pull-ups and a master that only pulls the lines low
//
// Functional notes
// - target updates sda after scl falls and holds it until next fall.
// - logic is fully static; no scl rate or pause limit.
// - after power-up, idle within 15 ms with scl high; no commands before.
// - with no transfer or measurement, return to idle on its own.
// - sda falling while scl high is start; begins a new transfer.
// - sda rising while scl high is stop; ends the current transfer.
// - bus busy from start until stop, free afterwards.
// - every such device answers one fixed, unconfigurable address.
// - header is address 1000000 plus direction bit; others ignored.
// - acknowledge each good byte by pulling sda low after 8th fall.
// - during held measurement keep scl low, release when done.
`timescale 1ns/100ps
module sensor_i2c_target_bus_layer #(
    parameter int STARTUP_CYCLES = i2c_target_pkg::STARTUP_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // open-drain bus lines
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // byte stream to the command logic
    output logic [7:0] rx_data,
    output logic rx_valid,
    // byte stream from the command logic
    input wire logic [7:0] tx_data,
    output logic tx_req,
    // measurement hold request from the command logic
    input wire logic hold_req,
    // status
    output logic ready,
    output logic bus_busy,
    output logic addressed,
    output logic rd_dir,
    output logic sleep
);
    logic rst_meta, rst_n;
    logic [i2c_target_pkg::BOOT_CNT_W-1:0] boot_cnt;
    i2c_target_pkg::link_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic mack_nack;

    bus_sense_if sense();

    bus_line_sense u_sense (
        .mclk(mclk),
        .rst_n(rst_n),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sense(sense)
    );

    // reset release through two flops
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // power-up wait counts only while scl is high
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            boot_cnt <= '0;
            ready <= 1'b0;
        end else if (!ready && sense.scl_lvl) begin
            if (boot_cnt == i2c_target_pkg::BOOT_CNT_W'(STARTUP_CYCLES - 1)) begin
                ready <= 1'b1;
            end else begin
                boot_cnt <= boot_cnt + 1'b1;
            end
        end
    end

    // bus occupancy, tracked even while still waking up
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bus_busy <= 1'b0;
        end else if (sense.start_seen) begin
            bus_busy <= 1'b1;
        end else if (sense.stop_seen) begin
            bus_busy <= 1'b0;
        end
    end

    // link state machine; every move waits for a sensed edge, so it is static
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= i2c_target_pkg::S_IDLE;
            bit_cnt <= '0;
            shift <= '0;
            sda_oe <= 1'b0;
            addressed <= 1'b0;
            rd_dir <= 1'b0;
            rx_data <= '0;
            rx_valid <= 1'b0;
            tx_req <= 1'b0;
            mack_nack <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            tx_req <= 1'b0;
            if (sense.start_seen && ready) begin
                // a repeated start drops whatever was in flight
                state <= i2c_target_pkg::S_ADDR;
                bit_cnt <= '0;
                sda_oe <= 1'b0;
                addressed <= 1'b0;
            end else if (sense.stop_seen) begin
                state <= i2c_target_pkg::S_IDLE;
                sda_oe <= 1'b0;
                addressed <= 1'b0;
            end else begin
                unique case (state)
                    i2c_target_pkg::S_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    i2c_target_pkg::S_ADDR, i2c_target_pkg::S_RX: begin
                        if (sense.scl_rise) begin
                            shift <= {shift[6:0], sense.sda_lvl};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (sense.scl_fall && bit_cnt == i2c_target_pkg::BYTE_BITS) begin
                            bit_cnt <= '0;
                            if (state == i2c_target_pkg::S_RX) begin
                                rx_data <= shift;
                                rx_valid <= 1'b1;
                                state <= i2c_target_pkg::S_ACK;
                                sda_oe <= 1'b1;
                            end else if (shift[7:1] == i2c_target_pkg::DEV_ADDR) begin
                                state <= i2c_target_pkg::S_ACK;
                                sda_oe <= 1'b1;
                                addressed <= 1'b1;
                                rd_dir <= (shift[0] == i2c_target_pkg::DIR_READ);
                            end else begin
                                state <= i2c_target_pkg::S_IDLE;
                            end
                        end
                    end
                    i2c_target_pkg::S_ACK: begin
                        // ack held through the ninth clock, dropped at its fall
                        if (sense.scl_fall) begin
                            if (rd_dir) begin
                                state <= i2c_target_pkg::S_TX;
                                shift <= tx_data;
                                sda_oe <= ~tx_data[7];
                                bit_cnt <= i2c_target_pkg::BIT_FIRST;
                                tx_req <= 1'b1;
                            end else begin
                                state <= i2c_target_pkg::S_RX;
                                sda_oe <= 1'b0;
                            end
                        end
                    end
                    i2c_target_pkg::S_TX: begin
                        if (sense.scl_fall) begin
                            if (bit_cnt == i2c_target_pkg::BYTE_BITS) begin
                                state <= i2c_target_pkg::S_MACK;
                                sda_oe <= 1'b0;
                            end else begin
                                shift <= {shift[6:0], 1'b0};
                                sda_oe <= ~shift[6];
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    i2c_target_pkg::S_MACK: begin
                        // master ack continues the read, nack ends it
                        if (sense.scl_rise) begin
                            mack_nack <= sense.sda_lvl;
                        end else if (sense.scl_fall) begin
                            if (mack_nack) begin
                                state <= i2c_target_pkg::S_IDLE;
                            end else begin
                                state <= i2c_target_pkg::S_TX;
                                shift <= tx_data;
                                sda_oe <= ~tx_data[7];
                                bit_cnt <= i2c_target_pkg::BIT_FIRST;
                                tx_req <= 1'b1;
                            end
                        end
                    end
                    default: begin
                        state <= i2c_target_pkg::S_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // clock stretch: grab scl only once the master has pulled it low
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            scl_oe <= 1'b0;
        end else if (!hold_req) begin
            scl_oe <= 1'b0;
        end else if (sense.scl_fall && addressed) begin
            scl_oe <= 1'b1;
        end
    end

    // lines are only ever pulled low, never driven high
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end
    end

    // sleep whenever nothing is going on
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sleep <= 1'b0;
        end else begin
            sleep <= ready && state == i2c_target_pkg::S_IDLE && !hold_req;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    property p_sda_hold_high;
        sense.scl_lvl && $past(sense.scl_lvl) |-> sda_oe == $past(sda_oe);
    endproperty
    a_sda_hold_high: assert property (p_sda_hold_high) else $error("sda moved with scl high");
    property p_static;
        ready && !sense.scl_rise && !sense.scl_fall && !sense.start_seen
            && !sense.stop_seen && state != i2c_target_pkg::S_IDLE |=> state == $past(state);
    endproperty
    a_static: assert property (p_static) else $error("state moved without bus event");
    property p_boot;
        $rose(ready) |-> $past(boot_cnt) == i2c_target_pkg::BOOT_CNT_W'(STARTUP_CYCLES - 1);
    endproperty
    a_boot: assert property (p_boot) else $error("ready before startup wait");
    property p_mute_boot;
        !ready |-> !sda_oe && state == i2c_target_pkg::S_IDLE;
    endproperty
    a_mute_boot: assert property (p_mute_boot) else $error("bus answered during startup");
    property p_sleep;
        ready && state == i2c_target_pkg::S_IDLE && !hold_req |=> sleep;
    endproperty
    a_sleep: assert property (p_sleep) else $error("no return to idle");
    property p_start;
        ready && sense.start_seen |=> state == i2c_target_pkg::S_ADDR && bit_cnt == 4'h0;
    endproperty
    a_start: assert property (p_start) else $error("start did not restart address");
    property p_stop;
        sense.stop_seen && !sense.start_seen |=> state == i2c_target_pkg::S_IDLE && !sda_oe;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not end transfer");
    property p_busy;
        (sense.start_seen || bus_busy) && !sense.stop_seen |=> bus_busy;
    endproperty
    a_busy: assert property (p_busy) else $error("busy dropped before stop");
    property p_addr;
        state == i2c_target_pkg::S_ADDR && sense.scl_fall && bit_cnt == i2c_target_pkg::BYTE_BITS
            && !sense.stop_seen |=> (state == i2c_target_pkg::S_ACK) == ($past(shift[7:1]) == 7'h40);
    endproperty
    a_addr: assert property (p_addr) else $error("address match wrong");
    property p_ack;
        state == i2c_target_pkg::S_ACK |-> sda_oe;
    endproperty
    a_ack: assert property (p_ack) else $error("ack not driven");
    property p_hold;
        !hold_req |=> !scl_oe;
    endproperty
    a_hold: assert property (p_hold) else $error("scl held after measurement");
    property p_release;
        state == i2c_target_pkg::S_RX || state == i2c_target_pkg::S_MACK
            || state == i2c_target_pkg::S_ADDR |-> !sda_oe;
    endproperty
    a_release: assert property (p_release) else $error("sda driven while listening");

    c_write_ack: cover property (state == i2c_target_pkg::S_ACK && !rd_dir);
    c_read_byte: cover property (state == i2c_target_pkg::S_MACK);
    c_restart: cover property (sense.start_seen && state == i2c_target_pkg::S_RX);
    c_stretch: cover property ($rose(scl_oe));
endmodule : sensor_i2c_target_bus_layer

/* File: src/i2c_target_pkg.sv */
// constants, types and timing for the two-wire target bus layer
// assumes a single 100 MHz system clock drives all logic
package i2c_target_pkg;
    // system clock rate and power-up wait
    localparam int CLK_FREQ_KHZ = 100000;
    localparam int STARTUP_TIME_MS = 15;
    // longest wait, rounds down to whole cycles
    localparam int STARTUP_CYCLES = STARTUP_TIME_MS * CLK_FREQ_KHZ;
    localparam int BOOT_CNT_W = 21;
    // fixed bus address, never configurable
    localparam logic [6:0] DEV_ADDR = 7'h40;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] BIT_FIRST = 4'h1;
    localparam logic DIR_READ = 1'b1;
    // link states, gray along idle-addr-ack-rx and ack-tx-mack
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_ADDR = 3'h1,
        S_ACK = 3'h3,
        S_RX = 3'h2,
        S_TX = 3'h7,
        S_MACK = 3'h5
    } link_state_t;
endpackage : i2c_target_pkg

/* File: src/bus_sense_if.sv */
// sampled bus levels and detected bus events
// driven by the line sensing module, read by the target core
`timescale 1ns/100ps
interface bus_sense_if;
    logic scl_lvl;
    logic sda_lvl;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    modport det (output scl_lvl, sda_lvl, scl_rise, scl_fall, start_seen, stop_seen);
    modport core (input scl_lvl, sda_lvl, scl_rise, scl_fall, start_seen, stop_seen);
endinterface : bus_sense_if

/* File: src/bus_line_sense.sv */
// synchronises the bus lines and finds clock edges, start and stop
// assumes scl and sda pins are asynchronous to mclk
`timescale 1ns/100ps
module bus_line_sense (
    // clock and synchronised reset
    input wire logic mclk,
    input wire logic rst_n,
    // raw bus levels
    input wire logic scl_i,
    input wire logic sda_i,
    // sensed events
    bus_sense_if.det sense
);
    logic scl_meta, scl_s, scl_d;
    logic sda_meta, sda_s, sda_d;

    // two-flop synchronisers plus one delay stage for edge finding
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            scl_meta <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_meta <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_meta <= scl_i;
            scl_s <= scl_meta;
            scl_d <= scl_s;
            sda_meta <= sda_i;
            sda_s <= sda_meta;
            sda_d <= sda_s;
        end
    end

    // sda moving while scl stays high marks start or stop
    assign sense.scl_lvl = scl_s;
    assign sense.sda_lvl = sda_s;
    assign sense.scl_rise = scl_s & ~scl_d;
    assign sense.scl_fall = ~scl_s & scl_d;
    assign sense.start_seen = scl_s & scl_d & ~sda_s & sda_d;
    assign sense.stop_seen = scl_s & scl_d & sda_s & ~sda_d;
endmodule : bus_line_sense

/* File: verification/i2c_master_model.sv */
// two-wire bus master model pulling open-drain lines low
// assumes pull-ups on both lines; the bench resolves the wire levels
`timescale 1ns/100ps
module i2c_master_model (
    // bus wire levels
    input wire logic scl,
    input wire logic sda,
    // pulls, high drags the line low
    output logic scl_low,
    output logic sda_low
);
    localparam real HALF = 62.5;
    // both lines released while idle
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // release scl, wait out a stretch, sample sda at both ends of high
    task automatic pulse(output logic s0, output logic s1);
        int n;
        n = 0;
        scl_low = 1'b0;
        // let the wire settle, then poll finely so an unstretched period stays 125 ns
        #1;
        while (scl !== 1'b1 && n < 500000) begin
            #1;
            n++;
        end
        s0 = sda;
        #(HALF - 1);
        s1 = sda;
        scl_low = 1'b1;
    endtask : pulse
    // one bit; sda moves well after the fall so no false start or stop
    task automatic xfer(input logic b, output logic s0, output logic s1);
        #30;
        sda_low = !b;
        #(HALF - 30);
        pulse(s0, s1);
    endtask : xfer
    // start, also usable as a repeated start from scl low
    task automatic start();
        #30;
        sda_low = 1'b0;
        #(HALF - 30);
        scl_low = 1'b0;
        #HALF;
        sda_low = 1'b1;
        #HALF;
        scl_low = 1'b1;
    endtask : start
    // stop leaves both lines released
    task automatic stop();
        #30;
        sda_low = 1'b1;
        #(HALF - 30);
        scl_low = 1'b0;
        #HALF;
        sda_low = 1'b0;
        #HALF;
    endtask : stop
    // byte msb first, ack level sampled in the ninth clock
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s1;
        for (int i = 7; i >= 0; i--) begin
            xfer(d[i], ack, s1);
        end
        xfer(1'b1, ack, s1);
    endtask : write_byte
    // read byte; ok is low if sda moved while scl was high
    task automatic read_byte(input logic nack, output logic [7:0] d, output logic ok);
        logic s0, s1;
        ok = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            xfer(1'b1, s0, s1);
            d[i] = s0;
            ok = ok & (s0 === s1);
        end
        xfer(nack, s0, s1);
    endtask : read_byte
endmodule : i2c_master_model

/* File: verification/sensor_i2c_target_bus_layer_test.sv */
// self-checking bench for the two-wire target bus layer
// assumes the master model and pull-ups on both bus lines
`timescale 1ns/100ps
module sensor_i2c_target_bus_layer_test;
    logic mclk, nrst, scl_o, scl_oe, sda_o, sda_oe, scl_low, sda_low, rx_valid, tx_req;
    logic hold_req, ready, bus_busy, addressed, rd_dir, sleep;
    logic [7:0] rx_data, tx_data;
    logic [31:0] seed = 32'h45;
    logic [7:0] exp_rx[$];
    logic [7:0] exp_rd[$];
    logic [7:0] bad[4] = '{8'h00, 8'h83, 8'h41, 8'hfe};
    int n_fail = 0;
    int check_count = 0;
    wire logic scl, sda;
    // pull-ups: a line is low while any party pulls it
    assign scl = !(scl_low || (scl_oe && !scl_o));
    assign sda = !(sda_low || (sda_oe && !sda_o));
    sensor_i2c_target_bus_layer #(.STARTUP_CYCLES(20)) sensor_i2c_target_bus_layer_i (
        .mclk(mclk), .nrst(nrst), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .rx_data(rx_data), .rx_valid(rx_valid),
        .tx_data(tx_data), .tx_req(tx_req), .hold_req(hold_req), .ready(ready),
        .bus_busy(bus_busy), .addressed(addressed), .rd_dir(rd_dir), .sleep(sleep));
    i2c_master_model i2c_master_model_i (.scl(scl), .sda(sda), .scl_low(scl_low),
        .sda_low(sda_low));
    // 100 MHz system clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = !mclk;
    end
    // xorshift stream for data bytes
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done
    // written bytes must come out in posting order, none unasked
    always @(posedge mclk) begin
        if (rx_valid === 1'b1) begin
            check(rx_data, (exp_rx.size() > 0) ? exp_rx.pop_front() : 8'hxx);
        end
    end
    // note the byte just taken for reading, then offer the next
    always @(posedge mclk) begin
        if (tx_req === 1'b1) begin
            exp_rd.push_back(tx_data);
            tx_data <= rnd();
        end
    end
    // watchdog, far beyond the expected run of about 4.4k cycles
    initial begin
        #500000;
        n_fail++;
        test_done();
    end
    // main sequence
    initial begin
        logic a, ok;
        logic [7:0] d;
        nrst = 1'b0;
        hold_req = 1'b0;
        tx_data = 8'h5a;
        repeat (4) @(posedge mclk);
        check({ready, bus_busy, sda_oe, scl_oe}, 8'h00);
        nrst <= 1'b1;
        repeat (19) @(posedge mclk);
        check(ready, 1'b0);
        for (int i = 0; i < 20 && ready !== 1'b1; i++) @(posedge mclk);
        @(posedge mclk);
        @(negedge mclk);
        check({ready, sleep}, 8'h03);
        $display("test startup done");
        // write with a long pause mid-transfer
        i2c_master_model_i.start();
        @(negedge mclk);
        check(bus_busy, 1'b1);
        i2c_master_model_i.write_byte(8'h80, a);
        check({a, addressed, rd_dir}, 8'h02);
        #20000; // long scl-low pause
        for (int i = 0; i < 3; i++) begin
            d = rnd();
            exp_rx.push_back(d);
            i2c_master_model_i.write_byte(d, a);
            check(a, 1'b0);
        end
        i2c_master_model_i.stop();
        repeat (5) @(negedge mclk);
        check({bus_busy, addressed, sda_oe, sleep}, 8'h01);
        $display("test write done");
        // foreign headers, then a partial byte cut by a repeated start
        i2c_master_model_i.start();
        foreach (bad[i]) begin
            i2c_master_model_i.write_byte(bad[i], a);
            check({a, addressed}, 8'h02);
            i2c_master_model_i.start();
        end
        i2c_master_model_i.write_byte(8'h80, a);
        check(a, 1'b0);
        for (int i = 0; i < 4; i++) i2c_master_model_i.xfer(i[0], a, ok);
        i2c_master_model_i.start();
        i2c_master_model_i.write_byte(8'h80, a);
        check({a, addressed}, 8'h01);
        d = rnd();
        exp_rx.push_back(d);
        i2c_master_model_i.write_byte(d, a);
        check(a, 1'b0);
        i2c_master_model_i.stop();
        $display("test address done");
        // read three bytes, the last refused
        i2c_master_model_i.start();
        i2c_master_model_i.write_byte(8'h81, a);
        check({a, rd_dir}, 8'h01);
        for (int i = 0; i < 3; i++) begin
            i2c_master_model_i.read_byte(i == 2, d, ok);
            check(ok, 1'b1);
            check(d, exp_rd.pop_front());
        end
        i2c_master_model_i.stop();
        repeat (5) @(negedge mclk);
        check({bus_busy, sda_oe}, 8'h00);
        $display("test read done");
        // measurement hold stretches the clock ahead of the data byte's first bit
        i2c_master_model_i.start();
        i2c_master_model_i.write_byte(8'h80, a);
        d = rnd();
        exp_rx.push_back(d);
        @(posedge mclk);
        hold_req <= 1'b1;
        fork
            i2c_master_model_i.write_byte(d, a);
            begin
                repeat (100) @(posedge mclk);
                check({scl_oe, scl, sleep}, 8'h04);
                hold_req <= 1'b0;
            end
        join
        check(a, 1'b0);
        i2c_master_model_i.stop();
        repeat (5) @(negedge mclk);
        check({6'h00, scl_oe, sleep}, 8'h01);
        check(exp_rx.size() == 0, 1'b1);
        $display("test stretch done");
        test_done();
    end
endmodule : sensor_i2c_target_bus_layer_test
